// ==== rtl/sfrbl_pkg.sv ====
// Shared constants and types for the serial flash read and buffer load block
package sfrbl_pkg;

  // Opcodes handled by the command decoder
  localparam logic [7:0] OP_READ_LOW_FREQ  = 8'h03;
  localparam logic [7:0] OP_READ_LOW_POWER = 8'h01;
  localparam logic [7:0] OP_PAGE_READ      = 8'hd2;
  localparam logic [7:0] OP_BUF1_READ_FAST = 8'hd4;
  localparam logic [7:0] OP_BUF1_READ_SLOW = 8'hd1;
  localparam logic [7:0] OP_BUF2_READ_FAST = 8'hd6;
  localparam logic [7:0] OP_BUF2_READ_SLOW = 8'hd3;
  localparam logic [7:0] OP_BUF1_WRITE     = 8'h84;
  localparam logic [7:0] OP_BUF2_WRITE     = 8'h87;

  // Address field layout
  localparam int         POS_W         = 9;
  localparam int         PAGE_FIELD_W  = 15;
  localparam int         STD_PAGE_LSB  = 9;
  localparam int         BIN_PAGE_LSB  = 8;
  localparam logic [8:0] PAGE_BYTES_STD = 9'h108;
  localparam logic [8:0] PAGE_BYTES_BIN = 9'h100;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;

  // Dummy byte counts per command
  localparam logic [2:0] DUMMY_NONE      = 3'h0;
  localparam logic [2:0] DUMMY_PAGE_READ = 3'h4;
  localparam logic [2:0] DUMMY_BUF_FAST  = 3'h1;

  // Write path FIFO: buffer select, position and data byte
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 1 + POS_W + 8;

  // Reset values
  localparam logic SO_OE_N_RESET = 1'b1;
  localparam logic SO_RESET      = 1'b0;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA_OUT, ST_DATA_IN, ST_IGNORE
  } sfrbl_state_t;

  typedef enum logic [1:0] {
    CMD_CONT, CMD_PAGE, CMD_BUF_READ, CMD_BUF_WRITE
  } sfrbl_cmd_t;

endpackage : sfrbl_pkg

// ==== rtl/sfrbl_fifo_if.sv ====
// Valid/ready carrier between the sequencer and its write FIFO
`timescale 1ns/1ps
`default_nettype none
interface sfrbl_fifo_if #(parameter int WIDTH = 18);
  logic [WIDTH-1:0] inData;
  logic             inValid;
  logic             inReady;
  logic [WIDTH-1:0] outData;
  logic             outValid;
  logic             outReady;

  modport fifo (input inData, inValid, outReady, output inReady, outData, outValid);
  modport user (output inData, inValid, outReady, input inReady, outData, outValid);
endinterface : sfrbl_fifo_if
`default_nettype wire

// ==== rtl/sfrbl_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sfrbl_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  sfrbl_fifo_if.fifo port
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0]   count;
  logic             doPush;
  logic             doPop;

  // Full and empty come straight from the occupancy count
  assign port.inReady  = (count != (PTR_W+1)'(DEPTH));
  assign port.outValid = (count != '0);
  assign port.outData  = mem[rdPtr];
  assign doPush        = port.inValid & port.inReady;
  assign doPop         = port.outValid & port.outReady;

  // Storage
  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      mem[wrPtr] <= port.inData;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (doPush && !doPop) begin
      count <= count + 1'b1;
    end else if (doPop && !doPush) begin
      count <= count - 1'b1;
    end
  end
endmodule : sfrbl_fifo
`default_nettype wire

// ==== rtl/sfrbl_sequencer.sv ====
// SPI slave command sequencer: array reads, page read, buffer read and buffer write
`timescale 1ns/1ps
`default_nettype none
module sfrbl_sequencer
  import sfrbl_pkg::*;
#(
  parameter int PAGE_ADDR_W = 15,
  parameter int FIFO_DEPTH_P = 16
) (
  input  wire logic                                sys_clk,
  input  wire logic                                sys_rst,
  input  wire logic                                spiCsN,
  input  wire logic                                spiSck,
  input  wire logic                                spiSi,
  output var  logic                                spiSo,
  output var  logic                                spiSoOeN,
  input  wire logic                                pageSize256,
  input  wire logic                                arrLoadEn,
  input  wire logic [PAGE_ADDR_W+sfrbl_pkg::POS_W-1:0] arrLoadAddr,
  input  wire logic [7:0]                          arrLoadData,
  output var  logic                                writeFifoReady,
  output var  logic                                writeDropped
);
  import sfrbl_pkg::*;

  localparam int IDX_W     = PAGE_ADDR_W + POS_W;
  localparam int ARR_DEPTH = (2 ** PAGE_ADDR_W) * int'(PAGE_BYTES_STD);
  localparam int BUF_DEPTH = 2 * int'(PAGE_BYTES_STD);
  localparam int BUF_IDX_W = POS_W + 1;

  // Byte count of a page or buffer for the selected size
  function automatic logic [POS_W-1:0] sizeOf(input logic bin);
    sizeOf = bin ? PAGE_BYTES_BIN : PAGE_BYTES_STD;
  endfunction : sizeOf

  // Next position inside one page or buffer, wrapping to zero
  function automatic logic [POS_W-1:0] nextPos(input logic [POS_W-1:0] pos,
                                               input logic [POS_W-1:0] size);
    nextPos = (pos == size - 1'b1) ? '0 : pos + 1'b1;
  endfunction : nextPos

  // Position field from a 24-bit address; out-of-range values fold back into the page
  function automatic logic [POS_W-1:0] posField(input logic [23:0] addr, input logic bin);
    logic [POS_W-1:0] raw;
    logic [POS_W-1:0] size;
    raw  = bin ? {1'b0, addr[7:0]} : addr[POS_W-1:0];
    size = sizeOf(bin);
    posField = (raw >= size) ? raw - size : raw;
  endfunction : posField

  logic [7:0]             arrMem [ARR_DEPTH];
  logic [7:0]             bufMem [BUF_DEPTH];

  sfrbl_state_t           state;
  sfrbl_cmd_t             cmd;
  logic                   bufSel;
  logic [2:0]             dummyLeft;
  logic [2:0]             bitCnt;
  logic [1:0]             byteCnt;
  logic [6:0]             inShift;
  logic [22:0]            addrShift;
  logic [PAGE_ADDR_W-1:0] page;
  logic [POS_W-1:0]       pos;
  logic [6:0]             outShift;
  logic [2:0]             outBit;
  logic [7:0]             fetchByte;
  logic                   sckPrev;

  logic                   csActive;
  logic                   sckRise;
  logic                   sckFall;
  logic                   byteDone;
  logic [7:0]             rxByte;
  logic [23:0]            addrFull;
  logic [POS_W-1:0]       size;
  logic [PAGE_ADDR_W-1:0] addrPage;
  logic [IDX_W-1:0]       arrIdx;
  logic [BUF_IDX_W-1:0]   bufIdx;
  logic [BUF_IDX_W-1:0]   drainIdx;
  logic                   drainStall;

  sfrbl_fifo_if #(.WIDTH(FIFO_WIDTH)) wq ();

  sfrbl_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .port    (wq.fifo)
  );

  // Pin edges, taken as synchronous to the system clock
  assign csActive = ~spiCsN;
  assign sckRise  = csActive & spiSck & ~sckPrev;
  assign sckFall  = csActive & ~spiSck & sckPrev;
  assign byteDone = sckRise & (bitCnt == BYTE_LAST_BIT);
  assign rxByte   = {inShift, spiSi};
  assign addrFull = {addrShift, spiSi};
  assign size     = sizeOf(pageSize256);

  // Page field sits one bit lower for the binary page size
  assign addrPage = pageSize256 ? addrFull[BIN_PAGE_LSB +: PAGE_ADDR_W]
                                : addrFull[STD_PAGE_LSB +: PAGE_ADDR_W];

  // Physical layout keeps 264-byte slots so both page sizes share one array
  assign arrIdx = IDX_W'(page) * IDX_W'(PAGE_BYTES_STD) + IDX_W'(pos);
  assign bufIdx = bufSel ? BUF_IDX_W'(pos) + BUF_IDX_W'(PAGE_BYTES_STD) : BUF_IDX_W'(pos);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sckPrev <= 1'b0;
    end else begin
      sckPrev <= spiSck;
    end
  end

  // Input shifter and bit counter; a frame always restarts on a whole byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !csActive) begin
      bitCnt    <= '0;
      inShift   <= '0;
      addrShift <= '0;
    end else if (sckRise) begin
      bitCnt    <= bitCnt + 1'b1;
      inShift   <= rxByte[6:0];
      addrShift <= addrFull[22:0];
    end
  end

  // Command state machine, advanced only on sampling edges
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !csActive) begin
      state     <= ST_OPCODE;
      byteCnt   <= '0;
    end else if (byteDone) begin
      case (state)
        ST_OPCODE: begin
          byteCnt <= '0;
          case (rxByte)
            OP_READ_LOW_FREQ, OP_READ_LOW_POWER, OP_PAGE_READ,
            OP_BUF1_READ_FAST, OP_BUF1_READ_SLOW, OP_BUF2_READ_FAST,
            OP_BUF2_READ_SLOW, OP_BUF1_WRITE, OP_BUF2_WRITE: begin
              state <= ST_ADDR;
            end
            default: begin
              state <= ST_IGNORE;
            end
          endcase
        end
        ST_ADDR: begin
          byteCnt <= byteCnt + 1'b1;
          if (byteCnt == ADDR_LAST_BYTE) begin
            if (cmd == CMD_BUF_WRITE) begin
              state <= ST_DATA_IN;
            end else if (dummyLeft == DUMMY_NONE) begin
              state <= ST_DATA_OUT;
            end else begin
              state <= ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          if (dummyLeft == 3'h1) begin
            state <= ST_DATA_OUT;
          end
        end
        ST_DATA_OUT, ST_DATA_IN, ST_IGNORE: begin
          state <= state;
        end
        default: begin
          state <= ST_IGNORE;
        end
      endcase
    end
  end

  // Opcode decode into command kind, buffer select and dummy count
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd       <= CMD_CONT;
      bufSel    <= 1'b0;
      dummyLeft <= DUMMY_NONE;
    end else if (byteDone && state == ST_OPCODE) begin
      case (rxByte)
        OP_READ_LOW_FREQ, OP_READ_LOW_POWER: begin
          cmd       <= CMD_CONT;
          dummyLeft <= DUMMY_NONE;
        end
        OP_PAGE_READ: begin
          cmd       <= CMD_PAGE;
          dummyLeft <= DUMMY_PAGE_READ;
        end
        OP_BUF1_READ_FAST, OP_BUF2_READ_FAST: begin
          cmd       <= CMD_BUF_READ;
          bufSel    <= (rxByte == OP_BUF2_READ_FAST);
          dummyLeft <= DUMMY_BUF_FAST;
        end
        OP_BUF1_READ_SLOW, OP_BUF2_READ_SLOW: begin
          cmd       <= CMD_BUF_READ;
          bufSel    <= (rxByte == OP_BUF2_READ_SLOW);
          dummyLeft <= DUMMY_NONE;
        end
        OP_BUF1_WRITE, OP_BUF2_WRITE: begin
          cmd       <= CMD_BUF_WRITE;
          bufSel    <= (rxByte == OP_BUF2_WRITE);
          dummyLeft <= DUMMY_NONE;
        end
        default: begin
          dummyLeft <= DUMMY_NONE;
        end
      endcase
    end else if (byteDone && state == ST_DUMMY) begin
      dummyLeft <= dummyLeft - 1'b1;
    end
  end

  // Page and byte position: loaded from the address, then stepped per byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      page <= '0;
      pos  <= '0;
    end else if (byteDone && state == ST_ADDR && byteCnt == ADDR_LAST_BYTE) begin
      // Buffer commands ignore the upper bits entirely
      page <= (cmd == CMD_BUF_READ || cmd == CMD_BUF_WRITE) ? '0 : addrPage;
      pos  <= posField(addrFull, pageSize256);
    end else if (byteDone && state == ST_DATA_IN) begin
      pos  <= nextPos(pos, size);
    end else if (sckFall && state == ST_DATA_OUT && outBit == 3'h0) begin
      case (cmd)
        CMD_CONT: begin
          pos <= nextPos(pos, size);
          if (pos == size - 1'b1) begin
            page <= page + 1'b1;
          end
        end
        CMD_PAGE: begin
          pos <= nextPos(pos, size);
        end
        CMD_BUF_READ: begin
          pos <= nextPos(pos, size);
        end
        default: begin
          pos <= pos;
        end
      endcase
    end
  end

  // Read fetch runs every cycle so the next byte waits before its first falling edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fetchByte <= '0;
    end else if (cmd == CMD_BUF_READ) begin
      fetchByte <= bufMem[bufIdx];
    end else begin
      fetchByte <= arrMem[arrIdx];
    end
  end

  // Serial output: a new byte starts on the falling edge after its last bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !csActive) begin
      spiSo    <= SO_RESET;
      spiSoOeN <= SO_OE_N_RESET;
      outShift <= '0;
      outBit   <= '0;
    end else if (state != ST_DATA_OUT) begin
      outBit   <= '0;
    end else if (sckFall) begin
      spiSoOeN <= 1'b0;
      outBit   <= outBit + 1'b1;
      if (outBit == 3'h0) begin
        spiSo    <= fetchByte[7];
        outShift <= fetchByte[6:0];
      end else begin
        spiSo    <= outShift[6];
        outShift <= {outShift[5:0], 1'b0};
      end
    end
  end

  // Received write bytes enter the FIFO; the SPI side cannot stall, so a full FIFO drops
  assign wq.inValid = byteDone && state == ST_DATA_IN;
  assign wq.inData  = {bufSel, pos, rxByte};
  assign writeFifoReady = wq.inReady;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      writeDropped <= 1'b0;
    end else begin
      writeDropped <= wq.inValid & ~wq.inReady;
    end
  end

  // Draining holds off while a buffer read frame owns the buffer port
  assign drainStall  = csActive & (cmd == CMD_BUF_READ);
  assign wq.outReady = ~drainStall;
  assign drainIdx    = wq.outData[FIFO_WIDTH-1] ?
                       BUF_IDX_W'(wq.outData[8 +: POS_W]) + BUF_IDX_W'(PAGE_BYTES_STD) :
                       BUF_IDX_W'(wq.outData[8 +: POS_W]);

  // Buffers are written only from the write FIFO, never by reads
  always_ff @(posedge sys_clk) begin
    if (wq.outValid && wq.outReady) begin
      bufMem[drainIdx] <= wq.outData[7:0];
    end
  end

  // Main array contents come from the load port only
  always_ff @(posedge sys_clk) begin
    if (arrLoadEn) begin
      arrMem[arrLoadAddr] <= arrLoadData;
    end
  end

endmodule : sfrbl_sequencer
`default_nettype wire

// ==== bench/sfrbl_seq_chk.sv ====
// Port-level assertions for the serial flash sequencer
`timescale 1ns/1ps
`default_nettype none
module sfrbl_seq_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiSo,
  input wire logic spiSoOeN,
  input wire logic writeFifoReady,
  input wire logic writeDropped
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Outputs leave reset floating and idle
  reset_idle_a:
    assert property ($fell(sys_rst) |-> spiSoOeN && !spiSo && writeFifoReady && !writeDropped)
    else $error("outputs not idle after reset");
  // Chip select rising floats the output on the next cycle
  cs_float_a:
    assert property ($rose(spiCsN) |=> spiSoOeN) else $error("output still driven after select rose");
  idle_float_a:
    assert property (spiCsN && $past(spiCsN) |-> spiSoOeN) else $error("output driven while deselected");
  // Output is enabled only after a clock fall inside a frame
  oe_cause_a:
    assert property ($fell(spiSoOeN) |-> !$past(spiCsN) && ((!$past(spiSck) && $past(spiSck, 2))
      || (!$past(spiSck, 2) && $past(spiSck, 3)))) else $error("output enabled without clock fall");
  // Data bits move only after a falling clock, never after a rise
  so_shift_a:
    assert property (!spiSoOeN && !$past(spiSoOeN) && $changed(spiSo) |->
      (!$past(spiSck) && $past(spiSck, 2)) || (!$past(spiSck, 2) && $past(spiSck, 3)))
    else $error("output bit changed without clock fall");
  rise_hold_a:
    assert property ($rose(spiSck) && !spiCsN ##1 !spiCsN |-> $stable(spiSo))
    else $error("output bit changed after clock rise");
  // A lost write byte follows a full FIFO and lasts one cycle
  drop_cause_a:
    assert property (writeDropped |-> !$past(writeFifoReady) ##1 !writeDropped)
    else $error("drop flag without full FIFO");
  oe_frame_a:
    assert property (!spiSoOeN |-> !$past(spiCsN)) else $error("output driven outside a frame");
endmodule : sfrbl_seq_chk

bind sfrbl_sequencer sfrbl_seq_chk chk (
  .sys_clk       (sys_clk),
  .sys_rst       (sys_rst),
  .spiCsN        (spiCsN),
  .spiSck        (spiSck),
  .spiSo         (spiSo),
  .spiSoOeN      (spiSoOeN),
  .writeFifoReady(writeFifoReady),
  .writeDropped  (writeDropped)
);
`default_nettype wire

// ==== bench/sfrbl_host_model.sv ====
// Host SPI controller model driving select, clock and serial input
`timescale 1ns/1ps
`default_nettype none
module sfrbl_host_model (
  input  wire logic sys_clk,
  input  wire logic spiSo,
  input  wire logic spiSoOeN,
  output var  logic spiCsN,
  output var  logic spiSck,
  output var  logic spiSi
);
  logic idleSck;

  initial begin
    spiCsN = 1'b1;
    spiSck = 1'b0;
    spiSi = 1'b0;
    idleSck = 1'b0;
  end

  // Park the clock at the mode's idle level, then select
  task automatic start(input logic mode3);
    @(posedge sys_clk);
    idleSck = mode3;
    spiSck <= mode3;
    repeat (4) @(posedge sys_clk);
    spiCsN <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : start

  // Phases of 4 cycles keep above the 2-cycle fetch minimum
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      spiSck <= 1'b0;
      spiSi <= tx[7-i];
      repeat (4) @(posedge sys_clk);
      rx[7-i] = spiSoOeN ? 1'bx : spiSo; // A floating pin never reads as data
      spiSck <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask : xfer

  // Select stays low until here; input flips so no stale level lingers
  task automatic stop();
    spiSck <= idleSck;
    repeat (4) @(posedge sys_clk);
    spiCsN <= 1'b1;
    spiSi <= ~spiSi;
    repeat (4) @(posedge sys_clk);
  endtask : stop
endmodule : sfrbl_host_model
`default_nettype wire

// ==== bench/sfrbl_tb.sv ====
// Self-checking testbench for the serial flash sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfrbl_pkg::*;
  localparam int PA = 3; // Eight pages keeps the array wrap reachable

  logic                sys_clk     = 1'b0;
  logic                sys_rst     = 1'b1;
  logic                pageSize256 = 1'b0;
  logic                arrLoadEn   = 1'b0;
  logic [PA+POS_W-1:0] arrLoadAddr = '0;
  logic [7:0]          arrLoadData = 8'h00;
  logic                spiCsN;
  logic                spiSck;
  logic                spiSi;
  logic                spiSo;
  logic                spiSoOeN;
  logic                writeFifoReady;
  logic                writeDropped;
  logic                sawDrop     = 1'b0;
  int                  n_errors    = 0;
  int                  cmp_count   = 0;

  always #5 sys_clk = ~sys_clk;

  // Drop pulses last one cycle, so latch them for the closing check
  always @(posedge sys_clk) begin
    if (writeDropped) begin
      sawDrop <= 1'b1;
    end
  end

  sfrbl_sequencer #(.PAGE_ADDR_W(PA), .FIFO_DEPTH_P(FIFO_DEPTH)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .spiCsN(spiCsN), .spiSck(spiSck), .spiSi(spiSi),
    .spiSo(spiSo), .spiSoOeN(spiSoOeN), .pageSize256(pageSize256), .arrLoadEn(arrLoadEn),
    .arrLoadAddr(arrLoadAddr), .arrLoadData(arrLoadData), .writeFifoReady(writeFifoReady),
    .writeDropped(writeDropped));

  sfrbl_host_model host (
    .sys_clk(sys_clk), .spiSo(spiSo), .spiSoOeN(spiSoOeN), .spiCsN(spiCsN), .spiSck(spiSck),
    .spiSi(spiSi));

  // Array pattern that differs per page and per byte
  function automatic logic [7:0] pat(input int p, input int b);
    return b[7:0] ^ {b[8], p[2:0], 4'h5};
  endfunction : pat

  task automatic check_eq(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check_eq

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // Opcode, three address bytes MSB first, then dummy bytes
  task automatic cmd(input logic m3, input logic [7:0] op, input logic [23:0] ad, input int nDummy);
    logic [7:0] rx;
    host.start(m3);
    host.xfer(op, 8, rx);
    for (int i = 2; i >= 0; i--) host.xfer(ad[8*i +: 8], 8, rx);
    repeat (nDummy) host.xfer(8'h00, 8, rx);
  endtask : cmd

  task automatic wr(input logic [7:0] b);
    logic [7:0] rx;
    host.xfer(b, 8, rx);
  endtask : wr

  task automatic rd(input logic [7:0] exp);
    logic [7:0] rx;
    host.xfer(8'h00, 8, rx);
    check_eq(rx, exp);
  endtask : rd

  task automatic fin();
    host.stop();
    check_eq({7'h00, spiSoOeN}, 8'h01);
  endtask : fin

  // Loads wrap at the buffer end; a partial last byte is dropped
  task automatic t_buf_write();
    logic [7:0] rx;
    cmd(1'b0, OP_BUF1_WRITE, 24'h000106, 0);
    wr(8'ha0);
    wr(8'ha1);
    wr(8'ha2);
    wr(8'ha3);
    host.stop();
    pageSize256 <= 1'b1;
    cmd(1'b0, OP_BUF2_WRITE, 24'h000001, 0);
    wr(8'h5a);
    host.stop();
    cmd(1'b0, OP_BUF2_WRITE, 24'h0000ff, 0);
    wr(8'hb0);
    wr(8'hb1);
    host.xfer(8'hc3, 4, rx);
    host.stop();
    pageSize256 <= 1'b0;
    repeat (20) @(posedge sys_clk);
    $display("t_buf_write done");
  endtask : t_buf_write

  // Continuous reads cross pages and wrap the array without gaps
  task automatic t_array_read();
    cmd(1'b0, OP_READ_LOW_FREQ, 24'((7 << 9) | 262), 0);
    rd(pat(7, 262));
    rd(pat(7, 263));
    rd(pat(0, 0));
    rd(pat(0, 1));
    fin();
    cmd(1'b1, OP_READ_LOW_POWER, 24'((2 << 9) | 263), 0);
    rd(pat(2, 263));
    rd(pat(3, 0));
    fin();
    pageSize256 <= 1'b1;
    cmd(1'b0, OP_READ_LOW_FREQ, 24'((1 << 8) | 255), 0);
    rd(pat(1, 255));
    rd(pat(2, 0));
    fin();
    pageSize256 <= 1'b0;
    $display("t_array_read done");
  endtask : t_array_read

  // Page read waits four dummy bytes and stays inside its page
  task automatic t_page_read();
    cmd(1'b0, OP_PAGE_READ, 24'((4 << 9) | 263), 4);
    rd(pat(4, 263));
    rd(pat(4, 0));
    rd(pat(4, 1));
    fin();
    pageSize256 <= 1'b1;
    cmd(1'b0, OP_PAGE_READ, 24'((5 << 8) | 255), 4);
    rd(pat(5, 255));
    rd(pat(5, 0));
    fin();
    pageSize256 <= 1'b0;
    $display("t_page_read done");
  endtask : t_page_read

  // Buffers survive the array reads; upper address bits are ignored
  task automatic t_buf_read();
    cmd(1'b0, OP_BUF1_READ_FAST, 24'habc106, 1);
    rd(8'ha0);
    rd(8'ha1);
    rd(8'ha2);
    rd(8'ha3);
    fin();
    cmd(1'b1, OP_BUF1_READ_SLOW, 24'h000107, 0);
    rd(8'ha1);
    rd(8'ha2);
    fin();
    pageSize256 <= 1'b1;
    cmd(1'b0, OP_BUF2_READ_FAST, 24'h5a5aff, 1);
    rd(8'hb0);
    rd(8'hb1);
    fin();
    cmd(1'b0, OP_BUF2_READ_SLOW, 24'h000000, 0);
    rd(8'hb1);
    rd(8'h5a);
    fin();
    pageSize256 <= 1'b0;
    $display("t_buf_read done");
  endtask : t_buf_read

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    check_eq({7'h00, writeFifoReady}, 8'h01);
    // Preload every physical slot through the load port
    for (int i = 0; i < 264 * 8; i++) begin
      arrLoadEn <= 1'b1;
      arrLoadAddr <= i[PA+POS_W-1:0];
      arrLoadData <= pat(i / 264, i % 264);
      @(posedge sys_clk);
    end
    arrLoadEn <= 1'b0;
    t_buf_write();
    t_array_read();
    t_page_read();
    t_buf_read();
    check_eq({7'h00, sawDrop}, 8'h00);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
